/* File: hdl/gpp_io_port.sv */
// One bit- or group-direction I/O port: data latch, direction, pin drive
`timescale 1ns/100ps
`default_nettype none
`include "gpp_map.svh"
module gpp_io_port #(
  parameter int PINS = 4,
  parameter bit GROUP = 1'b0
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  gpp_port_if.port bus,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_out
);
  localparam logic [3:0] PIN_MASK = (PINS == 4) ? `GPP_MASK_4PIN : `GPP_MASK_3PIN;
  localparam logic [3:0] DIR_MASK = GROUP ? `GPP_MASK_GROUP : PIN_MASK;

  gpp_pkg::gpp_nib_t data;
  gpp_pkg::gpp_nib_t dir;
  gpp_pkg::gpp_nib_t next_data;
  gpp_pkg::gpp_nib_t next_dir;
  gpp_pkg::gpp_nib_t next_pin;
  gpp_pkg::gpp_nib_t next_oe;
  gpp_pkg::gpp_nib_t dir_bits;
  logic [3:0] pin_sync;

  gpp_sync #(.W(4)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .d_in(pin_in),
    .q_out(pin_sync)
  );

  // A group port spreads its single direction bit over all four pins
  assign dir_bits = (GROUP ? {4{dir[0]}} : dir) & PIN_MASK;

  // Output bits read back the latch, input bits read the pin; padding bit reads 0
  assign bus.dm_rdata = ((dir_bits & data) | (~dir_bits & pin_sync)) & PIN_MASK;
  assign bus.rf_rdata = dir;

  // Latch and direction updates, then registered pin drive
  always_comb begin
    next_data = data;
    next_dir = dir;
    if (bus.dm_we) begin
      next_data = bus.wdata & PIN_MASK;
    end
    if (bus.rf_we) begin
      next_dir = bus.wdata & DIR_MASK;
    end
    next_pin = data;
    next_oe = dir_bits;
  end

  // Reset leaves every pin an input: general-purpose mode, nothing driven
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data <= `GPP_DATA_RST;
      dir <= `GPP_DIR_RST;
      pin_out <= `GPP_DATA_RST;
      pin_oe_out <= `GPP_DIR_RST;
    end else begin
      data <= next_data;
      dir <= next_dir;
      pin_out <= next_pin;
      pin_oe_out <= next_oe;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_pin_follows_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    bus.dm_we ##1 !bus.dm_we |=> pin_out == ($past(bus.wdata, 2) & PIN_MASK))
    else $error("Pin drive does not follow written data");
endmodule
`default_nettype wire

/* File: hdl/gpp_map.svh */
// Address map, reset values and masks of the general-purpose port block
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

// ------------------------------------------------------------
// Data-memory banks
// ------------------------------------------------------------
`define GPP_BANK_0 2'h0
`define GPP_BANK_1 2'h1
`define GPP_BANK_2 2'h2

// ------------------------------------------------------------
// Data-memory port registers (70H-73H reused in banks 0 and 1, 5CH-5FH in bank 2 only)
// ------------------------------------------------------------
`define GPP_DM_BITIO_A 7'h70
`define GPP_DM_BITIO_B 7'h71
`define GPP_DM_OUT_C 7'h72
`define GPP_DM_PORT_D 7'h73
`define GPP_DM_SEG_E 7'h5F
`define GPP_DM_SEG_F 7'h5E
`define GPP_DM_SEG_G 7'h5D
`define GPP_DM_SEG_H 7'h5C

// ------------------------------------------------------------
// Control register file and peripheral addresses
// ------------------------------------------------------------
`define GPP_RF_DIR_1D 7'h27
`define GPP_RF_DIR_1A 7'h35
`define GPP_RF_DIR_0B 7'h36
`define GPP_RF_DIR_0A 7'h37
`define GPP_PER_WIDE 7'h42

// ------------------------------------------------------------
// Reset values and field masks
// ------------------------------------------------------------
`define GPP_DATA_RST 4'h0
`define GPP_DIR_RST 4'h0
`define GPP_WIDE_RST 16'h0000
`define GPP_MASK_3PIN 4'h7
`define GPP_MASK_4PIN 4'hF
`define GPP_MASK_GROUP 4'h1

`endif

/* File: hdl/gpp_pkg.sv */
// Types shared by the general-purpose port block
package gpp_pkg;
  typedef logic [3:0] gpp_nib_t;
  typedef logic [1:0] gpp_bank_t;
  typedef logic [6:0] gpp_addr_t;
  typedef enum logic {
    GPP_DIR_IN = 1'b0,
    GPP_DIR_OUT = 1'b1
  } gpp_dir_e;
endpackage

/* File: hdl/gpp_port_block.sv */
// General-purpose port block: port registers, direction control, pin drive
//
// Summary of operation
// - Writing a port register drives each output pin high or low accordingly.
// - Reading an input port or input-direction pin returns the sampled pin level.
// - Each I/O port direction comes from a software-writable control register.
// - After reset ports 0A-0D and 1A-1D work as general-purpose ports.
// - After reset 2E-2H and wide port pins carry segment outputs until selected.
// - Separate select flags switch 2E, 2F, 2G, 2H and wide port individually.
// - Ports 2E-2H share one bank 2 location each with segment data.
// - Wide port data sits at peripheral 42H, also the key source data.
// - Per-bit direction of 0A, 0B, 1A comes from 37H, 36H, 35H.
// - One direction setting at 27H covers all four pins of port 1D.
// - Data at 70H, 71H bank 0 and 70H, 73H bank 1.
// - Inputs of 0D read at 73H bank 0, 1B at 71H bank 1.
// - Outputs 0C and 1C take data from 72H in banks 0 and 1.
// - Port registers are plain data memory, readable and writable bit-wise.
// - Bit ports choose direction per pin, group ports per four pins.
// - Wide port drives low for data 0 and high for data 1.
`timescale 1ns/100ps
`default_nettype none
`include "gpp_map.svh"
module gpp_port_block (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Data-memory access
  input wire logic [1:0] dm_bank_in,
  input wire logic [6:0] dm_addr_in,
  input wire logic dm_wr_in,
  input wire logic dm_rd_in,
  input wire logic [3:0] dm_wdata_in,
  output logic [3:0] dm_rdata_out,
  // Control register file access
  input wire logic [6:0] rf_addr_in,
  input wire logic rf_wr_in,
  input wire logic rf_rd_in,
  input wire logic [3:0] rf_wdata_in,
  output logic [3:0] rf_rdata_out,
  // Peripheral data buffer access
  input wire logic [6:0] per_addr_in,
  input wire logic per_wr_in,
  input wire logic per_rd_in,
  input wire logic [15:0] per_wdata_in,
  output logic [15:0] per_rdata_out,
  // Select flags from the segment controller's registers
  input wire logic segment_port_e_select_flag_in,
  input wire logic segment_port_f_select_flag_in,
  input wire logic segment_port_g_select_flag_in,
  input wire logic segment_port_h_select_flag_in,
  input wire logic wide_port_select_flag_in,
  // Segment waveforms to use while a pin is in segment mode
  input wire logic [15:0] lcd_segment_drive_in,
  input wire logic [15:0] lcd_wide_drive_in,
  output logic [15:0] segment_data_out,
  output logic [15:0] key_source_data_register_out,
  // Pins
  input wire logic [2:0] port_0a_bit_io_in,
  output logic [2:0] port_0a_bit_io_out,
  output logic [2:0] port_0a_bit_io_oe_out,
  input wire logic [3:0] port_0b_bit_io_in,
  output logic [3:0] port_0b_bit_io_out,
  output logic [3:0] port_0b_bit_io_oe_out,
  input wire logic [2:0] port_1a_bit_io_in,
  output logic [2:0] port_1a_bit_io_out,
  output logic [2:0] port_1a_bit_io_oe_out,
  input wire logic [3:0] port_1d_group_io_in,
  output logic [3:0] port_1d_group_io_out,
  output logic [3:0] port_1d_group_io_oe_out,
  input wire logic [3:0] port_0d_input_in,
  input wire logic [3:0] port_1b_input_in,
  output logic [3:0] port_0c_output_out,
  output logic [3:0] port_1c_output_out,
  output logic [15:0] shared_segment_pins_out,
  output logic [15:0] wide_key_source_port_out
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic dm_at(input gpp_pkg::gpp_bank_t b, input gpp_pkg::gpp_addr_t a,
                                 input gpp_pkg::gpp_bank_t wb, input gpp_pkg::gpp_addr_t wa);
    return (b == wb) && (a == wa);
  endfunction

  // Segment register index 0..3 is port E..H, E at the top address
  function automatic gpp_pkg::gpp_addr_t seg_addr(input int i);
    return `GPP_DM_SEG_E - 7'(i);
  endfunction

  // ------------------------------------------------------------
  // I/O ports
  // ------------------------------------------------------------
  gpp_port_if if_0a ();
  gpp_port_if if_0b ();
  gpp_port_if if_1a ();
  gpp_port_if if_1d ();
  logic [3:0] pin_0a;
  logic [3:0] oe_0a;
  logic [3:0] pin_1a;
  logic [3:0] oe_1a;
  logic [7:0] in_sync;

  // Data memory holds the port latches, the register file their directions
  assign if_0a.dm_we = dm_wr_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_0, `GPP_DM_BITIO_A);
  assign if_0b.dm_we = dm_wr_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_0, `GPP_DM_BITIO_B);
  assign if_1a.dm_we = dm_wr_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_1, `GPP_DM_BITIO_A);
  assign if_1d.dm_we = dm_wr_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_1, `GPP_DM_PORT_D);
  assign if_0a.rf_we = rf_wr_in && (rf_addr_in == `GPP_RF_DIR_0A);
  assign if_0b.rf_we = rf_wr_in && (rf_addr_in == `GPP_RF_DIR_0B);
  assign if_1a.rf_we = rf_wr_in && (rf_addr_in == `GPP_RF_DIR_1A);
  assign if_1d.rf_we = rf_wr_in && (rf_addr_in == `GPP_RF_DIR_1D);
  assign if_0a.wdata = dm_wr_in ? dm_wdata_in : rf_wdata_in;
  assign if_0b.wdata = dm_wr_in ? dm_wdata_in : rf_wdata_in;
  assign if_1a.wdata = dm_wr_in ? dm_wdata_in : rf_wdata_in;
  assign if_1d.wdata = dm_wr_in ? dm_wdata_in : rf_wdata_in;

  gpp_io_port #(.PINS(3), .GROUP(1'b0)) u_port_0a (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .bus(if_0a.port),
    .pin_in({1'b0, port_0a_bit_io_in}),
    .pin_out(pin_0a),
    .pin_oe_out(oe_0a)
  );

  gpp_io_port #(.PINS(4), .GROUP(1'b0)) u_port_0b (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .bus(if_0b.port),
    .pin_in(port_0b_bit_io_in),
    .pin_out(port_0b_bit_io_out),
    .pin_oe_out(port_0b_bit_io_oe_out)
  );

  gpp_io_port #(.PINS(3), .GROUP(1'b0)) u_port_1a (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .bus(if_1a.port),
    .pin_in({1'b0, port_1a_bit_io_in}),
    .pin_out(pin_1a),
    .pin_oe_out(oe_1a)
  );

  gpp_io_port #(.PINS(4), .GROUP(1'b1)) u_port_1d (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .bus(if_1d.port),
    .pin_in(port_1d_group_io_in),
    .pin_out(port_1d_group_io_out),
    .pin_oe_out(port_1d_group_io_oe_out)
  );

  // Three-pin ports have no pin behind bit 3
  assign port_0a_bit_io_out = pin_0a[2:0];
  assign port_0a_bit_io_oe_out = oe_0a[2:0];
  assign port_1a_bit_io_out = pin_1a[2:0];
  assign port_1a_bit_io_oe_out = oe_1a[2:0];

  // Input-only pins come from outside the clock domain
  gpp_sync #(.W(8)) u_in_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .d_in({port_1b_input_in, port_0d_input_in}),
    .q_out(in_sync)
  );

  // ------------------------------------------------------------
  // Output-only and shared registers
  // ------------------------------------------------------------
  gpp_pkg::gpp_nib_t out_0c;
  gpp_pkg::gpp_nib_t out_1c;
  gpp_pkg::gpp_nib_t seg_data [4];
  logic [15:0] wide_data;
  gpp_pkg::gpp_nib_t next_out_0c;
  gpp_pkg::gpp_nib_t next_out_1c;
  gpp_pkg::gpp_nib_t next_seg_data [4];
  logic [15:0] next_wide_data;
  logic [3:0] seg_sel;

  assign seg_sel = {segment_port_h_select_flag_in, segment_port_g_select_flag_in,
                    segment_port_f_select_flag_in, segment_port_e_select_flag_in};

  // Register writes; input-only addresses simply have no storage
  always_comb begin
    next_out_0c = out_0c;
    next_out_1c = out_1c;
    next_wide_data = wide_data;
    if (dm_wr_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_0, `GPP_DM_OUT_C)) begin
      next_out_0c = dm_wdata_in;
    end
    if (dm_wr_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_1, `GPP_DM_OUT_C)) begin
      next_out_1c = dm_wdata_in;
    end
    for (int i = 0; i < 4; i++) begin
      next_seg_data[i] = seg_data[i];
      if (dm_wr_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_2, seg_addr(i))) begin
        next_seg_data[i] = dm_wdata_in;
      end
    end
    if (per_wr_in && (per_addr_in == `GPP_PER_WIDE)) begin
      next_wide_data = per_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_0c <= `GPP_DATA_RST;
      out_1c <= `GPP_DATA_RST;
      wide_data <= `GPP_WIDE_RST;
      for (int i = 0; i < 4; i++) begin
        seg_data[i] <= `GPP_DATA_RST;
      end
    end else begin
      out_0c <= next_out_0c;
      out_1c <= next_out_1c;
      wide_data <= next_wide_data;
      for (int i = 0; i < 4; i++) begin
        seg_data[i] <= next_seg_data[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drive, registered so every pin toggles from a flop
  // ------------------------------------------------------------
  logic [15:0] next_shared_pins;
  logic [15:0] next_wide_pins;
  logic [15:0] next_seg_out;

  // Select flag low keeps the segment waveform on the pins
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_seg_out[4*i +: 4] = seg_data[i];
      next_shared_pins[4*i +: 4] = seg_sel[i] ? seg_data[i] : lcd_segment_drive_in[4*i +: 4];
    end
    next_wide_pins = wide_port_select_flag_in ? wide_data : lcd_wide_drive_in;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      port_0c_output_out <= `GPP_DATA_RST;
      port_1c_output_out <= `GPP_DATA_RST;
      shared_segment_pins_out <= `GPP_WIDE_RST;
      wide_key_source_port_out <= `GPP_WIDE_RST;
      segment_data_out <= `GPP_WIDE_RST;
      key_source_data_register_out <= `GPP_WIDE_RST;
    end else begin
      port_0c_output_out <= out_0c;
      port_1c_output_out <= out_1c;
      shared_segment_pins_out <= next_shared_pins;
      wide_key_source_port_out <= next_wide_pins;
      segment_data_out <= next_seg_out;
      key_source_data_register_out <= wide_data;
    end
  end

  // ------------------------------------------------------------
  // Read paths, answered one edge after the read strobe
  // ------------------------------------------------------------
  logic [3:0] next_dm_rdata;
  logic [3:0] next_rf_rdata;
  logic [15:0] next_per_rdata;

  // Unmapped addresses answer zero so the result is always defined
  always_comb begin
    next_dm_rdata = dm_rdata_out;
    if (dm_rd_in) begin
      next_dm_rdata = 4'h0;
      if (dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_0, `GPP_DM_BITIO_A)) begin
        next_dm_rdata = if_0a.dm_rdata;
      end else if (dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_0, `GPP_DM_BITIO_B)) begin
        next_dm_rdata = if_0b.dm_rdata;
      end else if (dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_0, `GPP_DM_OUT_C)) begin
        next_dm_rdata = out_0c;
      end else if (dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_0, `GPP_DM_PORT_D)) begin
        next_dm_rdata = in_sync[3:0];
      end else if (dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_1, `GPP_DM_BITIO_A)) begin
        next_dm_rdata = if_1a.dm_rdata;
      end else if (dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_1, `GPP_DM_BITIO_B)) begin
        next_dm_rdata = in_sync[7:4];
      end else if (dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_1, `GPP_DM_OUT_C)) begin
        next_dm_rdata = out_1c;
      end else if (dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_1, `GPP_DM_PORT_D)) begin
        next_dm_rdata = if_1d.dm_rdata;
      end
      for (int i = 0; i < 4; i++) begin
        if (dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_2, seg_addr(i))) begin
          next_dm_rdata = seg_data[i];
        end
      end
    end
  end

  always_comb begin
    next_rf_rdata = rf_rdata_out;
    if (rf_rd_in) begin
      unique case (rf_addr_in)
        `GPP_RF_DIR_0A: next_rf_rdata = if_0a.rf_rdata;
        `GPP_RF_DIR_0B: next_rf_rdata = if_0b.rf_rdata;
        `GPP_RF_DIR_1A: next_rf_rdata = if_1a.rf_rdata;
        `GPP_RF_DIR_1D: next_rf_rdata = if_1d.rf_rdata;
        default: next_rf_rdata = 4'h0;
      endcase
    end
    next_per_rdata = per_rdata_out;
    if (per_rd_in) begin
      next_per_rdata = (per_addr_in == `GPP_PER_WIDE) ? wide_data : 16'h0000;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dm_rdata_out <= 4'h0;
      rf_rdata_out <= 4'h0;
      per_rdata_out <= 16'h0000;
    end else begin
      dm_rdata_out <= next_dm_rdata;
      rf_rdata_out <= next_rf_rdata;
      per_rdata_out <= next_per_rdata;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  a_wide_pin_drive: assert property (
    (per_wr_in && per_addr_in == `GPP_PER_WIDE && wide_port_select_flag_in) ##1
    (!per_wr_in && wide_port_select_flag_in) |=> wide_key_source_port_out == $past(per_wdata_in, 2))
    else $error("Wide port pins do not match written data");
  a_segment_default: assert property (
    !segment_port_e_select_flag_in |=> shared_segment_pins_out[3:0] == $past(lcd_segment_drive_in[3:0]))
    else $error("Port E pins left segment mode without select");
  a_input_read: assert property (
    dm_rd_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_1, `GPP_DM_BITIO_B)
    |=> dm_rdata_out == $past(in_sync[7:4]))
    else $error("Port 1B read does not return pin level");
  a_out_c_drive: assert property (
    (dm_wr_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_0, `GPP_DM_OUT_C)) ##1 !dm_wr_in
    |=> port_0c_output_out == $past(dm_wdata_in, 2))
    else $error("Port 0C pins do not follow written data");
  a_seg_shared: assert property (
    dm_wr_in && dm_at(dm_bank_in, dm_addr_in, `GPP_BANK_2, `GPP_DM_SEG_H)
    ##1 !dm_wr_in |=> segment_data_out[15:12] == $past(dm_wdata_in, 2))
    else $error("Port H data not shared with segment data");
  a_dir_readback: assert property (
    (rf_wr_in && rf_addr_in == `GPP_RF_DIR_0A) ##1 (rf_rd_in && !rf_wr_in && rf_addr_in == `GPP_RF_DIR_0A)
    |=> rf_rdata_out == ($past(rf_wdata_in, 2) & `GPP_MASK_3PIN))
    else $error("Port 0A direction readback wrong");
  a_group_dir: assert property (
    (rf_wr_in && rf_addr_in == `GPP_RF_DIR_1D && rf_wdata_in[0]) ##1 !rf_wr_in
    |=> port_1d_group_io_oe_out == `GPP_MASK_4PIN)
    else $error("Group port did not turn all pins to output");
  a_bit3_zero: assert property (
    dm_rd_in && dm_addr_in == `GPP_DM_BITIO_A && (dm_bank_in == `GPP_BANK_0 || dm_bank_in == `GPP_BANK_1)
    |=> dm_rdata_out[3] == 1'b0)
    else $error("Padding bit of three-pin port reads one");

  c_wide_selected: cover property (per_wr_in && wide_port_select_flag_in ##2 wide_port_select_flag_in);
  c_seg_port_out: cover property (segment_port_h_select_flag_in && dm_wr_in && dm_bank_in == `GPP_BANK_2);
  c_bit_io_out: cover property (if_0b.rf_we ##1 if_0b.dm_we);
endmodule
`default_nettype wire

/* File: hdl/gpp_port_if.sv */
// Access strobes between the port block core and one I/O port
`timescale 1ns/100ps
`default_nettype none
interface gpp_port_if;
  logic dm_we;
  logic rf_we;
  gpp_pkg::gpp_nib_t wdata;
  gpp_pkg::gpp_nib_t dm_rdata;
  gpp_pkg::gpp_nib_t rf_rdata;
  modport ctrl (output dm_we, output rf_we, output wdata, input dm_rdata, input rf_rdata);
  modport port (input dm_we, input rf_we, input wdata, output dm_rdata, output rf_rdata);
endinterface
`default_nettype wire

/* File: hdl/gpp_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module gpp_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // First stage feeds only the second stage
  always_comb begin
    next_meta = d_in;
    next_q = meta;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= next_meta;
      q_out <= next_q;
    end
  end
endmodule
`default_nettype wire

/* File: tb/gpp_ext_circuit.sv */
// External circuit model at the I/O port pins
`timescale 1ns/100ps
`default_nettype none
module gpp_ext_circuit #(
  parameter int W = 4
) (
  input wire logic [W-1:0] drive_in,
  input wire logic [W-1:0] dev_out_in,
  input wire logic [W-1:0] dev_oe_in,
  output logic [W-1:0] pin_out
);
  // Device wins where it drives; elsewhere the outside circuit sets the level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_out[i] = dev_oe_in[i] ? dev_out_in[i] : drive_in[i];
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking testbench of the general-purpose port block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb;
  // ------------------------------------------------------------
  // Signals named as the block's ports, so .* joins them
  // ------------------------------------------------------------
  logic clk_sys_in = 1'b0, rstn_in = 1'b0;
  logic [1:0] dm_bank_in = 2'h0;
  logic [6:0] dm_addr_in = 7'h00, rf_addr_in = 7'h00, per_addr_in = 7'h00;
  logic dm_wr_in = 1'b0, dm_rd_in = 1'b0, rf_wr_in = 1'b0, rf_rd_in = 1'b0;
  logic per_wr_in = 1'b0, per_rd_in = 1'b0;
  logic [3:0] dm_wdata_in = 4'h0, rf_wdata_in = 4'h0, dm_rdata_out, rf_rdata_out, q4;
  logic [15:0] per_wdata_in = 16'h0000, per_rdata_out, segment_data_out, q16, exp16;
  logic [15:0] key_source_data_register_out, shared_segment_pins_out, wide_key_source_port_out;
  logic [15:0] lcd_segment_drive_in = 16'hA5C3, lcd_wide_drive_in = 16'h3C5A;
  logic [4:0] sel = 5'h00;
  wire logic segment_port_e_select_flag_in = sel[0];
  wire logic segment_port_f_select_flag_in = sel[1];
  wire logic segment_port_g_select_flag_in = sel[2];
  wire logic segment_port_h_select_flag_in = sel[3];
  wire logic wide_port_select_flag_in = sel[4];
  logic [2:0] port_0a_bit_io_in, port_0a_bit_io_out, port_0a_bit_io_oe_out, ext_0a = 3'h0;
  logic [2:0] port_1a_bit_io_in, port_1a_bit_io_out, port_1a_bit_io_oe_out, ext_1a = 3'h0;
  logic [3:0] port_0b_bit_io_in, port_0b_bit_io_out, port_0b_bit_io_oe_out, ext_0b = 4'h0;
  logic [3:0] port_1d_group_io_in, port_1d_group_io_out, port_1d_group_io_oe_out, ext_1d = 4'h0;
  logic [3:0] port_0d_input_in = 4'h0, port_1b_input_in = 4'h0;
  logic [3:0] port_0c_output_out, port_1c_output_out;
  int num_errors = 0, n_tests = 0, cyc = 0;

  // ------------------------------------------------------------
  // Block and the circuits at its two-way pins
  // ------------------------------------------------------------
  gpp_port_block gpp_port_block_inst (.*);
  gpp_ext_circuit #(.W(3)) gpp_ext_circuit_0a_inst (.drive_in(ext_0a),
    .dev_out_in(port_0a_bit_io_out), .dev_oe_in(port_0a_bit_io_oe_out), .pin_out(port_0a_bit_io_in));
  gpp_ext_circuit #(.W(3)) gpp_ext_circuit_1a_inst (.drive_in(ext_1a),
    .dev_out_in(port_1a_bit_io_out), .dev_oe_in(port_1a_bit_io_oe_out), .pin_out(port_1a_bit_io_in));
  gpp_ext_circuit #(.W(4)) gpp_ext_circuit_0b_inst (.drive_in(ext_0b),
    .dev_out_in(port_0b_bit_io_out), .dev_oe_in(port_0b_bit_io_oe_out), .pin_out(port_0b_bit_io_in));
  gpp_ext_circuit #(.W(4)) gpp_ext_circuit_1d_inst (.drive_in(ext_1d),
    .dev_out_in(port_1d_group_io_out), .dev_oe_in(port_1d_group_io_oe_out),
    .pin_out(port_1d_group_io_in));

  // ------------------------------------------------------------
  // Bus tasks: one-cycle strobe, data taken at the strobe's edge
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic dm(input logic w, input logic [1:0] b, input logic [6:0] a,
                    input logic [3:0] d, output logic [3:0] q);
    @(posedge clk_sys_in);
    {dm_bank_in, dm_addr_in, dm_wdata_in, dm_wr_in, dm_rd_in} <= {b, a, d, w, !w};
    tick(1);
    {dm_wr_in, dm_rd_in} <= 2'b00;
    q = dm_rdata_out;
  endtask
  task automatic rf(input logic w, input logic [6:0] a, input logic [3:0] d,
                    output logic [3:0] q);
    @(posedge clk_sys_in);
    {rf_addr_in, rf_wdata_in, rf_wr_in, rf_rd_in} <= {a, d, w, !w};
    tick(1);
    {rf_wr_in, rf_rd_in} <= 2'b00;
    q = rf_rdata_out;
  endtask
  task automatic per(input logic w, input logic [6:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk_sys_in);
    {per_addr_in, per_wdata_in, per_wr_in, per_rd_in} <= {a, d, w, !w};
    tick(1);
    {per_wr_in, per_rd_in} <= 2'b00;
    q = per_rdata_out;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    `CHK("oe 0A", 3'h0, port_0a_bit_io_oe_out)
    `CHK("oe 1D", 4'h0, port_1d_group_io_oe_out)
    `CHK("seg pins", lcd_segment_drive_in, shared_segment_pins_out)
    `CHK("wide pins", lcd_wide_drive_in, wide_key_source_port_out)
  endtask
  task automatic t_out();
    dm(1'b1, 2'h0, 7'h72, 4'h5, q4);
    dm(1'b1, 2'h1, 7'h72, 4'hA, q4);
    tick(1);
    `CHK("out 0C", 4'h5, port_0c_output_out)
    `CHK("out 1C", 4'hA, port_1c_output_out)
    dm(1'b0, 2'h0, 7'h72, 4'h0, q4);
    `CHK("rd 0C", 4'h5, q4)
  endtask
  task automatic t_in();
    @(posedge clk_sys_in);
    {port_0d_input_in, port_1b_input_in} <= 8'h96;
    tick(2);
    dm(1'b0, 2'h0, 7'h73, 4'h0, q4);
    `CHK("rd 0D", 4'h9, q4)
    dm(1'b0, 2'h1, 7'h71, 4'h0, q4);
    `CHK("rd 1B", 4'h6, q4)
  endtask
  // Input bits must read the pin while output bits read the latch
  task automatic t_bit();
    rf(1'b1, 7'h37, 4'hD, q4);
    rf(1'b1, 7'h35, 4'h2, q4);
    rf(1'b1, 7'h36, 4'hF, q4);
    rf(1'b0, 7'h37, 4'h0, q4);
    `CHK("dir 0A", 4'h5, q4)
    dm(1'b1, 2'h0, 7'h70, 4'hF, q4);
    dm(1'b1, 2'h1, 7'h70, 4'h2, q4);
    dm(1'b1, 2'h0, 7'h71, 4'hC, q4);
    @(posedge clk_sys_in);
    {ext_0a, ext_1a} <= 6'b000101;
    tick(2);
    `CHK("oe 0A", 3'h5, port_0a_bit_io_oe_out)
    `CHK("out 0A", 3'h5, port_0a_bit_io_out & 3'h5)
    `CHK("oe 1A", 3'h2, port_1a_bit_io_oe_out)
    `CHK("out 1A", 3'h2, port_1a_bit_io_out & 3'h2)
    `CHK("out 0B", 4'hC, port_0b_bit_io_out)
    dm(1'b0, 2'h0, 7'h70, 4'h0, q4);
    `CHK("rd 0A", 4'h5, q4)
    dm(1'b0, 2'h1, 7'h70, 4'h0, q4);
    `CHK("rd 1A", 4'h7, q4)
  endtask
  task automatic t_group();
    dm(1'b1, 2'h1, 7'h73, 4'h9, q4);
    @(posedge clk_sys_in);
    ext_1d <= 4'h6;
    tick(2);
    dm(1'b0, 2'h1, 7'h73, 4'h0, q4);
    `CHK("rd 1D in", 4'h6, q4)
    rf(1'b1, 7'h27, 4'hF, q4);
    tick(1);
    `CHK("oe 1D", 4'hF, port_1d_group_io_oe_out)
    `CHK("out 1D", 4'h9, port_1d_group_io_out)
    rf(1'b0, 7'h27, 4'h0, q4);
    `CHK("dir 1D", 4'h1, q4)
  endtask
  // Flags are raised one at a time; nibbles not yet selected stay on segment drive
  task automatic t_seg();
    exp16 = lcd_segment_drive_in;
    for (int i = 0; i < 4; i++) begin
      dm(1'b1, 2'h2, 7'h5F - 7'(i), 4'h9 - 4'(i), q4);
    end
    tick(1);
    `CHK("seg data", 16'h6789, segment_data_out)
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      sel[i] <= 1'b1;
      tick(1);
      exp16[4*i+:4] = 4'h9 - 4'(i);
      `CHK("seg pins", exp16, shared_segment_pins_out)
    end
  endtask
  task automatic t_wide();
    per(1'b1, 7'h42, 16'hB38E, q16);
    tick(1);
    `CHK("key src", 16'hB38E, key_source_data_register_out)
    `CHK("wide lcd", lcd_wide_drive_in, wide_key_source_port_out)
    @(posedge clk_sys_in);
    sel[4] <= 1'b1;
    tick(1);
    `CHK("wide pins", 16'hB38E, wide_key_source_port_out)
    per(1'b0, 7'h42, 16'h0000, q16);
    `CHK("rd wide", 16'hB38E, q16)
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog, verdict and main sequence
  // ------------------------------------------------------------
  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Whole run needs under a hundred cycles; a hang is cut well beyond that
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    tick(2);
    t_reset();
    t_out();
    t_in();
    t_bit();
    t_group();
    t_seg();
    t_wide();
    stop_test();
  end
endmodule
`default_nettype wire
